// [rtl/dma_regs_pkg.sv]
// constants for the dma channel address and count register block
package dma_regs_pkg;
   localparam int NUM_CHANNELS = 4;
   localparam int REG_INDEX_BITS = 3;
   localparam int CHANNEL_BITS = 2;
   // register index inside a channel window; byte address = channel*32 + index*4
   localparam logic [2:0] SOURCE_ADDRESS = 3'h0;
   localparam logic [2:0] DESTINATION_ADDRESS = 3'h1;
   localparam logic [2:0] ADDRESS_OFFSET = 3'h2;
   localparam logic [2:0] TOTAL_TRANSFER_COUNT = 3'h3;
   localparam logic [2:0] REPEAT_BLOCK_SIZE = 3'h4;
   localparam logic [2:0] CHANNEL_CONTROL = 3'h5;
   localparam int CHANNEL_LSB = 5;
   localparam int INDEX_LSB = 2;
   // channel_control fields
   localparam int ENABLE_BIT = 0;
   localparam int SINGLE_ADDRESS_BIT = 1;
   localparam int DIRECTION_BIT = 2;
   localparam int SIZE_LSB = 4;
   localparam int MODE_LSB = 6;
   localparam int COUNT_END_BIT = 16;
   localparam logic [31:0] RESET_VALUE = 32'h00000000;
   localparam logic [15:0] RELOAD_LSB = 16'h0010;
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2,
      SIZE_BAD = 2'h3
   } access_size_t;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_BLOCK = 2'h1,
      MODE_REPEAT = 2'h2,
      MODE_BAD = 2'h3
   } transfer_mode_t;
endpackage

// [rtl/dma_channel_addr_count_regs.sv]
// four-channel dma address, offset, count and block size registers
`timescale 1ns/10ps
module dma_channel_addr_count_regs #(
   parameter int ADDR_WIDTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [31:0] readData,
   input wire logic [3:0] transferDone,
   input wire logic [3:0] sourceStep,
   input wire logic [3:0] destinationStep,
   input wire logic [3:0] sourceDecrement,
   input wire logic [3:0] destinationDecrement,
   input wire logic [3:0] sourceUseOffset,
   input wire logic [3:0] destinationUseOffset,
   output logic [3:0] channelEnable,
   output logic [3:0] countEnd,
   output logic [3:0] blockEnd,
   output logic [127:0] sourceAddress,
   output logic [127:0] destinationAddress
);

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] srcReg [dma_regs_pkg::NUM_CHANNELS];
   logic [31:0] dstReg [dma_regs_pkg::NUM_CHANNELS];
   logic [31:0] offsetReg [dma_regs_pkg::NUM_CHANNELS];
   logic [31:0] countReg [dma_regs_pkg::NUM_CHANNELS];
   logic [15:0] reloadReg [dma_regs_pkg::NUM_CHANNELS];
   logic [15:0] remainReg [dma_regs_pkg::NUM_CHANNELS];
   logic [7:0] controlReg [dma_regs_pkg::NUM_CHANNELS];
   logic [3:0] endFlag;
   logic [1:0] selChannel;
   logic [2:0] selIndex;
   logic inRange;

   assign selChannel = address[dma_regs_pkg::CHANNEL_LSB +: dma_regs_pkg::CHANNEL_BITS];
   assign selIndex = address[dma_regs_pkg::INDEX_LSB +: dma_regs_pkg::REG_INDEX_BITS];
   assign inRange = (address >> (dma_regs_pkg::CHANNEL_LSB + dma_regs_pkg::CHANNEL_BITS)) == '0;

   function automatic logic [31:0] size_bytes(input logic [1:0] code);
      logic [31:0] result;
      result = 32'h00000001;
      case (code)
         dma_regs_pkg::SIZE_WORD: result = 32'h00000002;
         dma_regs_pkg::SIZE_LONG: result = 32'h00000004;
         default: result = 32'h00000001;
      endcase
      return result;
   endfunction

   function automatic logic [31:0] next_address(input logic [31:0] current,
         input logic step, input logic down, input logic useOffset,
         input logic [31:0] offset, input logic [31:0] unit);
      logic [31:0] result;
      result = current;
      if (useOffset) begin
         result = current + offset;
      end else if (step && down) begin
         result = current - unit;
      end else if (step) begin
         result = current + unit;
      end
      return result;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // one register set per channel
   genvar ch;
   generate
      for (ch = 0; ch < dma_regs_pkg::NUM_CHANNELS; ch++) begin : g_chan
         logic hit;
         logic done;
         logic single;
         logic direction;
         logic [1:0] sizeCode;
         logic [1:0] modeCode;
         logic [31:0] unit;
         logic [31:0] next_count;
         logic usesBlock;

         assign hit = writeStrobe && inRange && (selChannel == 2'(ch));
         assign done = transferDone[ch] && controlReg[ch][dma_regs_pkg::ENABLE_BIT];
         assign single = controlReg[ch][dma_regs_pkg::SINGLE_ADDRESS_BIT];
         assign direction = controlReg[ch][dma_regs_pkg::DIRECTION_BIT];
         assign sizeCode = controlReg[ch][dma_regs_pkg::SIZE_LSB +: 2];
         assign modeCode = controlReg[ch][dma_regs_pkg::MODE_LSB +: 2];
         assign unit = size_bytes(sizeCode);
         // subtract access size; saturate so a short tail still ends at zero
         assign next_count = (countReg[ch] > unit) ? countReg[ch] - unit : 32'h00000000;
         // normal mode leaves the block counter alone
         assign usesBlock = (modeCode == dma_regs_pkg::MODE_BLOCK)
            || (modeCode == dma_regs_pkg::MODE_REPEAT);

         always_ff @(posedge clock) begin
            if (reset) begin
               srcReg[ch] <= dma_regs_pkg::RESET_VALUE;
            end else if (hit && selIndex == dma_regs_pkg::SOURCE_ADDRESS) begin
               srcReg[ch] <= writeData;
            end else if (done && !(single && direction)) begin
               srcReg[ch] <= next_address(srcReg[ch], sourceStep[ch],
                  sourceDecrement[ch], sourceUseOffset[ch], offsetReg[ch], unit);
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               dstReg[ch] <= dma_regs_pkg::RESET_VALUE;
            end else if (hit && selIndex == dma_regs_pkg::DESTINATION_ADDRESS) begin
               dstReg[ch] <= writeData;
            end else if (done && !(single && !direction)) begin
               dstReg[ch] <= next_address(dstReg[ch], destinationStep[ch],
                  destinationDecrement[ch], destinationUseOffset[ch], offsetReg[ch], unit);
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               offsetReg[ch] <= dma_regs_pkg::RESET_VALUE;
            end else if (hit && selIndex == dma_regs_pkg::ADDRESS_OFFSET) begin
               offsetReg[ch] <= writeData;
            end
         end

         // byte count, all 32 bits significant
         always_ff @(posedge clock) begin
            if (reset) begin
               countReg[ch] <= dma_regs_pkg::RESET_VALUE;
            end else if (hit && selIndex == dma_regs_pkg::TOTAL_TRANSFER_COUNT) begin
               // all-ones loads as the largest size
               countReg[ch] <= writeData;
            end else if (done && countReg[ch] != 32'h00000000) begin
               countReg[ch] <= next_count;
            end
         end

         // upper half is the size in units, zero wraps to 65536
         // only software writes the upper half
         always_ff @(posedge clock) begin
            if (reset) begin
               reloadReg[ch] <= 16'h0000;
            end else if (hit && selIndex == dma_regs_pkg::REPEAT_BLOCK_SIZE) begin
               reloadReg[ch] <= writeData[31:16];
            end
         end

         // count down; a transfer at one reloads instead of stepping to zero
         // 16-bit unit counter gives 1..65536 units of any size
         always_ff @(posedge clock) begin
            if (reset) begin
               remainReg[ch] <= 16'h0000;
            end else if (hit && selIndex == dma_regs_pkg::REPEAT_BLOCK_SIZE) begin
               remainReg[ch] <= writeData[15:0];
            end else if (done && usesBlock) begin
               if (remainReg[ch] == 16'h0001) begin
                  remainReg[ch] <= reloadReg[ch];
               end else begin
                  remainReg[ch] <= remainReg[ch] - 16'h0001;
               end
            end
         end

         // mode and size held in the control register
         always_ff @(posedge clock) begin
            if (reset) begin
               controlReg[ch] <= 8'h00;
            end else if (hit && selIndex == dma_regs_pkg::CHANNEL_CONTROL) begin
               controlReg[ch] <= writeData[7:0];
            end else if (done && countReg[ch] != 32'h00000000
                  && next_count == 32'h00000000) begin
               controlReg[ch][dma_regs_pkg::ENABLE_BIT] <= 1'b0;
            end
         end

         // set on final transfer wins over a software clear
         always_ff @(posedge clock) begin
            if (reset) begin
               endFlag[ch] <= 1'b0;
            end else if (done && countReg[ch] != 32'h00000000
                  && next_count == 32'h00000000) begin
               endFlag[ch] <= 1'b1;
            end else if (hit && selIndex == dma_regs_pkg::CHANNEL_CONTROL
                  && !writeData[dma_regs_pkg::COUNT_END_BIT]) begin
               endFlag[ch] <= 1'b0;
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               blockEnd[ch] <= 1'b0;
            end else begin
               blockEnd[ch] <= done && usesBlock && remainReg[ch] == 16'h0001;
            end
         end

         assign channelEnable[ch] = controlReg[ch][dma_regs_pkg::ENABLE_BIT];
         assign countEnd[ch] = endFlag[ch];
         assign sourceAddress[32*ch +: 32] = srcReg[ch];
         assign destinationAddress[32*ch +: 32] = dstReg[ch];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // count read returns the live remaining size
   always_ff @(posedge clock) begin
      if (reset) begin
         readData <= 32'h00000000;
      end else if (readStrobe && inRange) begin
         case (selIndex)
            dma_regs_pkg::SOURCE_ADDRESS: readData <= srcReg[selChannel];
            dma_regs_pkg::DESTINATION_ADDRESS: readData <= dstReg[selChannel];
            dma_regs_pkg::ADDRESS_OFFSET: readData <= offsetReg[selChannel];
            dma_regs_pkg::TOTAL_TRANSFER_COUNT: readData <= countReg[selChannel];
            dma_regs_pkg::REPEAT_BLOCK_SIZE:
               readData <= {reloadReg[selChannel], remainReg[selChannel]};
            dma_regs_pkg::CHANNEL_CONTROL:
               readData <= {15'h0000, endFlag[selChannel], 8'h00, controlReg[selChannel]};
            default: readData <= 32'h00000000;
         endcase
      end else begin
         // data stand only in the cycle after the read
         readData <= 32'h00000000;
      end
   end

endmodule

// [testbench/dma_regs_sva.sv]
// port assertions for the dma register block, watched on channel 0
`timescale 1ns/10ps
module dma_regs_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [31:0] readData,
   input wire logic [3:0] transferDone,
   input wire logic [3:0] channelEnable,
   input wire logic [3:0] countEnd,
   input wire logic [3:0] blockEnd,
   input wire logic [127:0] sourceAddress,
   input wire logic [127:0] destinationAddress
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   a_read_idle_zero: assert property (!readStrobe |=> readData == 32'h00000000)
      else $error("read data not zero outside a read answer");
   a_source_hold: assert property (!transferDone[0] && !writeStrobe |=> $stable(sourceAddress[31:0]))
      else $error("source address moved without a cause");
   a_dest_hold: assert property (!transferDone[0] && !writeStrobe |=> $stable(destinationAddress[31:0]))
      else $error("destination address moved without a cause");
   a_enable_by_write: assert property ($rose(channelEnable[0]) |-> $past(writeStrobe))
      else $error("channel enabled without a write");
   a_enable_drop_end: assert property ($fell(channelEnable[0]) && !$past(writeStrobe) |-> countEnd[0])
      else $error("channel stopped without count end");
   a_flag_cause: assert property ($rose(countEnd[0]) |-> $past(transferDone[0] && channelEnable[0]))
      else $error("count end set without a transfer");
   a_flag_stops: assert property ($rose(countEnd[0]) |-> !channelEnable[0])
      else $error("channel still enabled at count end");
   a_flag_sticky: assert property (countEnd[0] && !writeStrobe |=> countEnd[0])
      else $error("count end flag lost without a write");
   a_block_cause: assert property (blockEnd[0] |-> $past(transferDone[0] && channelEnable[0]))
      else $error("block end without a transfer");
endmodule
bind dma_channel_addr_count_regs dma_regs_checker checker_inst (
   .clock(clock), .reset(reset), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
   .readData(readData), .transferDone(transferDone), .channelEnable(channelEnable),
   .countEnd(countEnd), .blockEnd(blockEnd), .sourceAddress(sourceAddress),
   .destinationAddress(destinationAddress));

// [testbench/transfer_agent.sv]
// model of the channel transfer logic that reports finished data transfers
`timescale 1ns/10ps
module transfer_agent (
   input wire logic clock,
   output logic [3:0] transferDone,
   output logic [3:0] stepOn,
   output logic [3:0] stepDown,
   output logic [3:0] useOffset
);
   initial begin
      transferDone = 4'h0;
      stepOn = 4'h0;
      stepDown = 4'h0;
      useOffset = 4'h0;
   end
   task automatic move(input int ch, input logic stp, input logic dn, input logic off);
      @(posedge clock);
      stepOn[ch] <= stp;
      stepDown[ch] <= dn;
      useOffset[ch] <= off;
      transferDone[ch] <= 1'b1;
      @(posedge clock);
      transferDone[ch] <= 1'b0;
   endtask
endmodule

// [testbench/testbench.sv]
// register and transfer tests for the dma address and count registers
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] address = 8'h00;
   logic [31:0] writeData = 32'h00000000;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic [31:0] readData;
   logic [3:0] transferDone, stepOn, stepDown, useOffset, channelEnable, countEnd, blockEnd;
   logic [127:0] sourceAddress, destinationAddress;
   int n_fail = 0;
   int checked = 0;
   always #5 clock = ~clock;
   transfer_agent agent (.clock(clock), .transferDone(transferDone), .stepOn(stepOn),
      .stepDown(stepDown), .useOffset(useOffset));
   dma_channel_addr_count_regs #(.ADDR_WIDTH(8)) uut (.clock(clock), .reset(reset),
      .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
      .readStrobe(readStrobe), .readData(readData), .transferDone(transferDone),
      .sourceStep(stepOn), .destinationStep(stepOn), .sourceDecrement(stepDown),
      .destinationDecrement(stepDown), .sourceUseOffset(useOffset),
      .destinationUseOffset(useOffset), .channelEnable(channelEnable), .countEnd(countEnd),
      .blockEnd(blockEnd), .sourceAddress(sourceAddress),
      .destinationAddress(destinationAddress));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input int ch, input int idx, input logic [31:0] d);
      @(posedge clock);
      address <= 8'(ch * 32 + idx * 4);
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask
   // read answer stands only in the cycle after the strobe edge
   // full-word reads only; no register write lands on a transfer edge
   task automatic rd(input int ch, input int idx, input logic [31:0] exp);
      @(posedge clock);
      address <= 8'(ch * 32 + idx * 4);
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 chk("readData", readData, exp);
   endtask
   task automatic setup(input logic [31:0] ctl, input logic [31:0] cnt);
      wr(0, 0, 32'h00000100);
      wr(0, 1, 32'h00000200);
      wr(0, 3, cnt);
      wr(0, 5, ctl);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      for (int c = 0; c < 4; c++) for (int i = 0; i < 5; i++) rd(c, i, 32'h00000000);
      for (int c = 0; c < 4; c++) for (int i = 0; i < 5; i++) wr(c, i, 32'(c * 16 + i));
      for (int c = 0; c < 4; c++) for (int i = 0; i < 5; i++) rd(c, i, 32'(c * 16 + i));
      wr(0, 6, 32'hFFFFFFFF);
      rd(0, 6, 32'h00000000);
      wr(0, 4, 32'h00020002);
      for (int s = 0; s < 3; s++) begin
         setup(32'(1 + s * 16), 32'h0000000A);
         agent.move(0, 1'b1, 1'b0, 1'b0);
         rd(0, 3, 32'(10 - (1 << s)));
         rd(0, 0, 32'(256 + (1 << s)));
         rd(0, 1, 32'(512 + (1 << s)));
      end
      rd(0, 4, 32'h00020002);
      setup(32'h00000001, 32'h00000001);
      agent.move(0, 1'b1, 1'b0, 1'b0);
      #1 chk("countEnd", 32'(countEnd[0]), 32'h00000001);
      rd(0, 5, 32'h00010000);
      agent.move(0, 1'b1, 1'b0, 1'b0);
      rd(0, 0, 32'h00000101);
      setup(32'h00000001, 32'h00000000);
      agent.move(0, 1'b1, 1'b0, 1'b0);
      rd(0, 3, 32'h00000000);
      chk("countEnd", {countEnd[0], channelEnable[0]}, 32'h00000001);
      setup(32'h00000021, 32'hFFFFFFFF);
      agent.move(0, 1'b1, 1'b0, 1'b0);
      rd(0, 3, 32'hFFFFFFFB);
      for (int d = 0; d < 2; d++) begin
         setup(32'(3 + d * 4), 32'h00000010);
         agent.move(0, 1'b1, 1'b0, 1'b0);
         rd(0, 0, 32'(257 - d));
         rd(0, 1, 32'(512 + d));
      end
      wr(0, 2, 32'h00000040);
      setup(32'h00000001, 32'h00000010);
      agent.move(0, 1'b1, 1'b0, 1'b1);
      agent.move(0, 1'b1, 1'b1, 1'b0);
      rd(0, 0, 32'h0000013F);
      rd(0, 1, 32'h0000023F);
      for (int m = 1; m < 3; m++) begin
         wr(0, 4, 32'h00020002);
         setup(32'(1 + m * 64), 32'h00000010);
         agent.move(0, 1'b1, 1'b0, 1'b0);
         rd(0, 4, 32'h00020001);
         agent.move(0, 1'b1, 1'b0, 1'b0);
         #1 chk("blockEnd", 32'(blockEnd[0]), 32'h00000001);
         rd(0, 4, 32'h00020002);
      end
      wr(0, 4, 32'h00000000);
      setup(32'h00000041, 32'h00000010);
      agent.move(0, 1'b1, 1'b0, 1'b0);
      rd(0, 4, 32'h0000FFFF);
      test_done;
   end
endmodule
